/* File: src/asq_pkg.sv */
// Types shared by the step 5 sequencer configuration block.
package asq_pkg;
	typedef enum logic [1:0]
	{
		ASQ_NEG_GROUND = 2'h0,
		ASQ_NEG_INPUT7 = 2'h1,
		ASQ_NEG_AUTO = 2'h3
	} asq_neg_t;

	typedef struct packed
	{
		logic in_sequence;
		logic [2:0] gain;
		asq_neg_t neg;
		logic [3:0] pos;
		logic temp_sensor;
		logic int_short;
	} asq_step_t;
endpackage

/* File: src/asq_step5_cfg.sv */
// Step 5 configuration register of the auxiliary converter sequencer, with an AXI4-Lite slave.
// Function
// - The register sits at index 95h (byte address 254h) and resets to 0005h.
// - Bit 15 includes step 5 in the sequence when set and excludes it when clear.
// - Bits 14:13 select gain 1 for 00b, gain 2 for 01b and gain 4 for 10b or 11b.
// - Bit 4 selects analog ground when 0 and analog input seven when 1 as negative input.
// - Bits 3:0 select the positive input, codes 0 to 7 being external inputs zero to seven.
// - For positive codes with an automatic negative input, bit 4 has no effect.
// - Positive code 1000b routes the temperature sensor with an automatic negative input.
// - Positive code 1001b applies the internal short to ground with an automatic negative input.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "asq_step5_defs.svh"

module asq_step5_cfg
(
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic [13:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic [13:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	output logic [31:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I,
	input wire logic SEQ_AT_STEP5_I,
	output asq_pkg::asq_step_t STEP5_CFG_O,
	output logic STEP5_CONVERT_O,
	output logic STEP5_SKIP_O
);

	logic [15:0] cfg_q;
	logic [15:0] cfg_d;
	logic aw_got_q;
	logic w_got_q;
	logic aw_hit_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_take;
	logic w_take;
	logic do_write;
	logic ar_take;
	logic ar_hit;
	logic [15:0] strb_mask;
	asq_pkg::asq_step_t step_d;

	assign aw_take = AWVALID_I && AWREADY_O;
	assign w_take = WVALID_I && WREADY_O;
	assign ar_take = ARVALID_I && ARREADY_O;
	assign ar_hit = ARADDR_I[`ASQ_ADDR_WORD_HI:`ASQ_ADDR_WORD_LO] == `ASQ_S5_INDEX;
	assign do_write = aw_got_q && w_got_q && !BVALID_O;

	// Write address is held until the matching data has arrived, in either order.
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			aw_got_q <= 1'b0;
			aw_hit_q <= 1'b0;
			AWREADY_O <= 1'b0;
		end
		else if (aw_take)
		begin
			aw_got_q <= 1'b1;
			aw_hit_q <= AWADDR_I[`ASQ_ADDR_WORD_HI:`ASQ_ADDR_WORD_LO] == `ASQ_S5_INDEX;
			AWREADY_O <= 1'b0;
		end
		else if (do_write)
		begin
			aw_got_q <= 1'b0;
		end
		else if (!aw_got_q && !BVALID_O)
		begin
			AWREADY_O <= 1'b1;
		end
	end

	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			w_got_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			WREADY_O <= 1'b0;
		end
		else if (w_take)
		begin
			w_got_q <= 1'b1;
			wdata_q <= WDATA_I;
			wstrb_q <= WSTRB_I;
			WREADY_O <= 1'b0;
		end
		else if (do_write)
		begin
			w_got_q <= 1'b0;
		end
		else if (!w_got_q && !BVALID_O)
		begin
			WREADY_O <= 1'b1;
		end
	end

	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			BVALID_O <= 1'b0;
			BRESP_O <= `ASQ_RESP_OKAY;
		end
		else if (do_write)
		begin
			BVALID_O <= 1'b1;
			BRESP_O <= aw_hit_q ? `ASQ_RESP_OKAY : `ASQ_RESP_SLVERR;
		end
		else if (BVALID_O && BREADY_I)
		begin
			BVALID_O <= 1'b0;
		end
	end

	// Byte lanes 0 and 1 carry the register; reserved bits are never stored.
	always_comb
	begin
		strb_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}} & `ASQ_S5_WMASK;
		cfg_d = (cfg_q & ~strb_mask) | (wdata_q[15:0] & strb_mask);
	end

	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			cfg_q <= `ASQ_S5_RESET;
		end
		else if (do_write && aw_hit_q)
		begin
			cfg_q <= cfg_d;
		end
	end

	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			ARREADY_O <= 1'b0;
			RVALID_O <= 1'b0;
			RDATA_O <= 32'h0000_0000;
			RRESP_O <= `ASQ_RESP_OKAY;
		end
		else if (ar_take)
		begin
			ARREADY_O <= 1'b0;
			RVALID_O <= 1'b1;
			RDATA_O <= ar_hit ? {16'h0000, cfg_q} : 32'h0000_0000;
			RRESP_O <= ar_hit ? `ASQ_RESP_OKAY : `ASQ_RESP_SLVERR;
		end
		else if (RVALID_O && RREADY_I)
		begin
			RVALID_O <= 1'b0;
		end
		else if (!RVALID_O)
		begin
			ARREADY_O <= 1'b1;
		end
	end

	// Decoded step settings for the converter and input multiplexer.
	always_comb
	begin
		step_d.in_sequence = cfg_q[`ASQ_S5_EN];
		case (cfg_q[`ASQ_S5_GAIN_HI:`ASQ_S5_GAIN_LO])
			`ASQ_GAIN_CODE_X1: step_d.gain = `ASQ_GAIN_X1;
			`ASQ_GAIN_CODE_X2: step_d.gain = `ASQ_GAIN_X2;
			default: step_d.gain = `ASQ_GAIN_X4;
		endcase
		step_d.pos = cfg_q[`ASQ_S5_POS_HI:`ASQ_S5_POS_LO];
		if (cfg_q[`ASQ_S5_POS_HI])
		begin
			step_d.neg = asq_pkg::ASQ_NEG_AUTO;
		end
		else if (cfg_q[`ASQ_S5_NEG])
		begin
			step_d.neg = asq_pkg::ASQ_NEG_INPUT7;
		end
		else
		begin
			step_d.neg = asq_pkg::ASQ_NEG_GROUND;
		end
		step_d.temp_sensor = step_d.pos == `ASQ_POS_TEMP;
		step_d.int_short = step_d.pos == `ASQ_POS_SHORT;
	end

	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			STEP5_CFG_O <= '{in_sequence: 1'b0, gain: `ASQ_GAIN_X1, neg: asq_pkg::ASQ_NEG_GROUND,
				pos: 4'(`ASQ_S5_RESET), temp_sensor: 1'b0, int_short: 1'b0};
		end
		else
		begin
			STEP5_CFG_O <= step_d;
		end
	end

	// The sequencer reaching step 5 either converts or passes straight on.
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			STEP5_CONVERT_O <= 1'b0;
			STEP5_SKIP_O <= 1'b0;
		end
		else
		begin
			STEP5_CONVERT_O <= SEQ_AT_STEP5_I && STEP5_CFG_O.in_sequence;
			STEP5_SKIP_O <= SEQ_AT_STEP5_I && !STEP5_CFG_O.in_sequence;
		end
	end

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!NRST_I);

	reserved_reads_zero_a: assert property (RDATA_O[31:16] == 16'h0000
		&& (RDATA_O[15:0] & ~`ASQ_S5_WMASK) == 16'h0000)
		else $error("reserved bits read nonzero");

	reserved_unstored_a: assert property ((cfg_q & ~`ASQ_S5_WMASK) == 16'h0000)
		else $error("reserved bits stored");

	reg_write_lands_a: assert property ((do_write && aw_hit_q && wstrb_q[1:0] == 2'h3)
		|=> cfg_q == ($past(wdata_q[15:0]) & `ASQ_S5_WMASK))
		else $error("full write not stored");

	write_miss_kept_a: assert property ((do_write && !aw_hit_q)
		|=> cfg_q == $past(cfg_q) && BRESP_O == `ASQ_RESP_SLVERR)
		else $error("unmapped write not refused");

	read_returns_reg_a: assert property ((ar_take && ar_hit)
		|=> RVALID_O && RDATA_O[15:0] == $past(cfg_q))
		else $error("read data differs from register");

	read_miss_zero_a: assert property ((ar_take && !ar_hit)
		|=> RDATA_O == 32'h0000_0000 && RRESP_O == `ASQ_RESP_SLVERR)
		else $error("unmapped read not refused");

	gain_one_a: assert property (
		(cfg_q[`ASQ_S5_GAIN_HI:`ASQ_S5_GAIN_LO] == `ASQ_GAIN_CODE_X1)
		|=> STEP5_CFG_O.gain == `ASQ_GAIN_X1)
		else $error("gain code 00 not gain one");

	gain_two_a: assert property (
		(cfg_q[`ASQ_S5_GAIN_HI:`ASQ_S5_GAIN_LO] == `ASQ_GAIN_CODE_X2)
		|=> STEP5_CFG_O.gain == `ASQ_GAIN_X2)
		else $error("gain code 01 not gain two");

	gain_four_a: assert property (cfg_q[`ASQ_S5_GAIN_HI]
		|=> STEP5_CFG_O.gain == `ASQ_GAIN_X4)
		else $error("gain code 1x not gain four");

	neg_auto_a: assert property (cfg_q[`ASQ_S5_POS_HI]
		|=> STEP5_CFG_O.neg == asq_pkg::ASQ_NEG_AUTO)
		else $error("negative input not automatic");

	neg_manual_a: assert property (!cfg_q[`ASQ_S5_POS_HI]
		|=> STEP5_CFG_O.neg[0] == $past(cfg_q[`ASQ_S5_NEG]) && !STEP5_CFG_O.neg[1])
		else $error("negative select not followed");

	temp_route_a: assert property (
		(cfg_q[`ASQ_S5_POS_HI:`ASQ_S5_POS_LO] == `ASQ_POS_TEMP)
		|=> STEP5_CFG_O.temp_sensor && !STEP5_CFG_O.int_short)
		else $error("temperature sensor not routed");

	short_route_a: assert property (
		(cfg_q[`ASQ_S5_POS_HI:`ASQ_S5_POS_LO] == `ASQ_POS_SHORT)
		|=> STEP5_CFG_O.int_short && !STEP5_CFG_O.temp_sensor)
		else $error("internal short not applied");

	side_route_none_a: assert property (
		(cfg_q[`ASQ_S5_POS_HI:`ASQ_S5_POS_LO] != `ASQ_POS_TEMP
		&& cfg_q[`ASQ_S5_POS_HI:`ASQ_S5_POS_LO] != `ASQ_POS_SHORT)
		|=> !STEP5_CFG_O.temp_sensor && !STEP5_CFG_O.int_short)
		else $error("internal source routed for external code");

	pos_follow_a: assert property (##1
		STEP5_CFG_O.pos == $past(cfg_q[`ASQ_S5_POS_HI:`ASQ_S5_POS_LO]))
		else $error("positive select not followed");

	include_follow_a: assert property (##1
		STEP5_CFG_O.in_sequence == $past(cfg_q[`ASQ_S5_EN]))
		else $error("include bit not followed");

	step_skip_a: assert property ((SEQ_AT_STEP5_I && !cfg_q[`ASQ_S5_EN]
		&& !$past(cfg_q[`ASQ_S5_EN]))
		|=> STEP5_SKIP_O && !STEP5_CONVERT_O)
		else $error("disabled step converted");

	step_include_a: assert property ((SEQ_AT_STEP5_I && STEP5_CFG_O.in_sequence)
		|=> STEP5_CONVERT_O && !STEP5_SKIP_O)
		else $error("enabled step not converted");

	no_step_no_pulse_a: assert property (!SEQ_AT_STEP5_I
		|=> !STEP5_CONVERT_O && !STEP5_SKIP_O)
		else $error("step pulse without sequencer arrival");

	bresp_hold_a: assert property ((BVALID_O && !BREADY_I) |=> BVALID_O && $stable(BRESP_O))
		else $error("write response dropped");

endmodule

/* File: src/asq_step5_defs.svh */
// Constants for the step 5 sequencer configuration register.
`ifndef ASQ_STEP5_DEFS_SVH
`define ASQ_STEP5_DEFS_SVH
`define ASQ_S5_INDEX 12'h0095
`define ASQ_S5_RESET 16'h0005
`define ASQ_S5_WMASK 16'hE01F
`define ASQ_S5_EN 15
`define ASQ_S5_GAIN_HI 14
`define ASQ_S5_GAIN_LO 13
`define ASQ_S5_NEG 4
`define ASQ_S5_POS_HI 3
`define ASQ_S5_POS_LO 0
`define ASQ_POS_TEMP 4'h8
`define ASQ_POS_SHORT 4'h9
`define ASQ_GAIN_X1 3'h1
`define ASQ_GAIN_X2 3'h2
`define ASQ_GAIN_X4 3'h4
`define ASQ_GAIN_CODE_X1 2'h0
`define ASQ_GAIN_CODE_X2 2'h1
`define ASQ_RESP_OKAY 2'h0
`define ASQ_RESP_SLVERR 2'h2
`define ASQ_ADDR_WORD_HI 13
`define ASQ_ADDR_WORD_LO 2
`endif

/* File: verif/asq_step5_cfg_test.sv */
// Self-checking testbench for the step 5 sequencer configuration register.
`timescale 1ns/10ps

module asq_step5_cfg_test;
	logic clk, nrst, awv, wv, bready, arv, rready, seq;
	logic [13:0] awa, ara;
	logic [31:0] wd, v;
	logic [15:0] exp_v;
	logic [3:0] ws;
	logic [1:0] BRESP, RRESP;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CONV, SKIP;
	logic [31:0] RDATA;
	asq_pkg::asq_step_t cfg;
	logic [33:0] rq[$], bq[$], sq[$];
	int bad_count, checked;

	asq_step5_cfg DUT
	(
		.CLK_I(clk), .NRST_I(nrst), .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(AWREADY),
		.WDATA_I(wd), .WSTRB_I(ws), .WVALID_I(wv), .WREADY_O(WREADY), .BRESP_O(BRESP),
		.BVALID_O(BVALID), .BREADY_I(bready), .ARADDR_I(ara), .ARVALID_I(arv),
		.ARREADY_O(ARREADY), .RDATA_O(RDATA), .RRESP_O(RRESP), .RVALID_O(RVALID),
		.RREADY_I(rready), .SEQ_AT_STEP5_I(seq), .STEP5_CFG_O(cfg), .STEP5_CONVERT_O(CONV),
		.STEP5_SKIP_O(SKIP)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Expected decoded view of a register value.
	function automatic asq_pkg::asq_step_t ex(input logic [15:0] r);
		asq_pkg::asq_step_t s;
		s.in_sequence = r[15];
		s.gain = r[14] ? 3'h4 : (r[13] ? 3'h2 : 3'h1);
		s.neg = r[3] ? asq_pkg::ASQ_NEG_AUTO
			: (r[4] ? asq_pkg::ASQ_NEG_INPUT7 : asq_pkg::ASQ_NEG_GROUND);
		s.pos = r[3:0];
		s.temp_sensor = (r[3:0] == 4'h8);
		s.int_short = (r[3:0] == 4'h9);
		return s;
	endfunction

	task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] r);
		bq.push_back({32'h0000_0000, r});
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		fork
			begin do @(posedge clk); while (AWREADY !== 1'b1); awv <= 1'b0; end
			begin do @(posedge clk); while (WREADY !== 1'b1); wv <= 1'b0; end
		join
		bready <= 1'b1;
		do @(posedge clk); while (BVALID !== 1'b1);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [13:0] a, input logic [33:0] e);
		rq.push_back(e);
		ara <= a;
		arv <= 1'b1;
		do @(posedge clk); while (ARREADY !== 1'b1);
		arv <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk); while (RVALID !== 1'b1);
		rready <= 1'b0;
	endtask

	task automatic step(input logic inc);
		sq.push_back({32'h0000_0000, inc, ~inc});
		seq <= 1'b1;
		@(posedge clk);
		seq <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// Results are matched against the oldest pending note as they appear.
	always @(posedge clk)
	begin
		if (RVALID === 1'b1 && rready === 1'b1)
			chk({RRESP, RDATA}, rq.pop_front());
		if (BVALID === 1'b1 && bready === 1'b1)
			chk({32'h0000_0000, BRESP}, bq.pop_front());
		if ((CONV | SKIP) === 1'b1)
			chk({32'h0000_0000, CONV, SKIP}, sq.pop_front());
	end

	task automatic end_of_test;
		chk(34'(rq.size() + bq.size() + sq.size()), 34'h0_0000_0000);
		$display("Checks made: %0d, mismatches: %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (5000) @(posedge clk);
		bad_count++;
		end_of_test();
	end

	initial
	begin
		{nrst, awv, wv, bready, arv, rready, seq, awa, ara, wd} = '0;
		ws = 4'h3;
		bad_count = 0;
		checked = 0;
		void'($urandom(32'ha1b5));
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(14'h0254, 34'h0_0000_0005);
		chk({22'h00_0000, cfg}, {22'h00_0000, ex(16'h0005)});
		for (int i = 0; i < 16; i++)
		begin
			v = $urandom;
			v[3:0] = 4'(i);
			v[4] = v[0] ^ v[1];
			v[15:13] = {v[0], v[2:1]};
			wr(14'h0254, v, 2'h0);
			exp_v = v[15:0] & 16'hE01F;
			repeat (2) @(posedge clk);
			chk({22'h00_0000, cfg}, {22'h00_0000, ex(exp_v)});
			rd(14'h0254, {18'h0_0000, exp_v});
			step(exp_v[15]);
		end
		// Only byte lane 0 is written: bits 4:0 change, the upper field keeps its value.
		ws <= 4'h1;
		wr(14'h0254, 32'h0000_FFFF, 2'h0);
		ws <= 4'h3;
		exp_v = (exp_v & 16'hFF00) | 16'h001F;
		rd(14'h0254, {18'h0_0000, exp_v});
		for (int k = 0; k < 2; k++)
		begin
			wr(k ? 14'h0258 : 14'h0094, 32'hFFFF_FFFF, 2'h2);
			rd(k ? 14'h0258 : 14'h0094, {2'h2, 32'h0000_0000});
		end
		rd(14'h0254, {18'h0_0000, exp_v});
		// A reset in mid-run must bring back the documented reset value.
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(14'h0254, 34'h0_0000_0005);
		chk({22'h00_0000, cfg}, {22'h00_0000, ex(16'h0005)});
		step(1'b0);
		end_of_test();
	end
endmodule
